// *** core/vpa_palette_port.sv ***
// Palette access port: index registers, data port, mask and lookup
// What this block does
// - One palette per pipe, host access steerable
// - 256 entries of three bytes, indirect access
// - Reads return red, green, blue in turn
// - Read index increments after blue read
// - Entry updated only after all three writes
// - Write index increments after blue write
// - Indexed pixel ANDed with pixel mask
// - State shows 00 after write, 11 after read
// - Read index write abandons partial write
// - Any index write returns sequencer to red
// - Access works in every display mode
// - Write/lookup collision repeats previous pixel
// - Shared data port, separate read/write index
`timescale 1ns/1ps
module vpa_palette_port #(
    parameter int NUM_PIPES = 2
) (
    input  wire logic                          sys_clk,
    input  wire logic                          sys_rst,
    input  wire logic [vpa_pkg::ADDR_W-1:0]    busAddr,
    input  wire logic                          busWrite,
    input  wire logic                          busRead,
    input  wire logic [7:0]                    busWrData,
    output logic      [7:0]                    busRdData,
    output logic                               busRdValid,
    input  wire logic                          palSel,
    input  wire logic [NUM_PIPES-1:0]          pixValid,
    input  wire logic [NUM_PIPES-1:0]          idxMode,
    input  wire logic [NUM_PIPES-1:0][7:0]     pixIndex,
    output logic      [NUM_PIPES-1:0][23:0]    pixColour,
    output logic      [NUM_PIPES-1:0]          pixColourValid
);
    import vpa_pkg::*;

    logic     [7:0]                 readIndex;
    logic     [7:0]                 writeIndex;
    logic     [7:0]                 pixelMask;
    logic     [1:0]                 indexState;
    logic     [7:0]                 redHeld;
    logic     [7:0]                 greenHeld;
    vpa_seq_t                       byteSel;
    logic                           rdIdxWr;
    logic                           wrIdxWr;
    logic                           dataWr;
    logic                           dataRd;
    logic                           commit;
    logic     [23:0]                commitData;
    logic     [NUM_PIPES-1:0][23:0] hostData;
    logic     [NUM_PIPES-1:0][23:0] lookData;
    logic     [NUM_PIPES-1:0][7:0]  lookIdx;
    logic     [NUM_PIPES-1:0]       collide;
    logic     [23:0]                selEntry;
    logic     [7:0]                 selRed;
    logic     [7:0]                 next_rdData;

    // Same address, direction picks the register
    assign rdIdxWr    = busWrite && (busAddr == OFF_RD_STATE);
    assign wrIdxWr    = busWrite && (busAddr == OFF_WR_INDEX);
    assign dataWr     = busWrite && (busAddr == OFF_DATA);
    assign dataRd     = busRead && (busAddr == OFF_DATA);
    assign commit     = dataWr && (byteSel == SEQ_BLUE);
    assign commitData = {redHeld, greenHeld, busWrData};
    assign selEntry   = hostData[palSel];
    assign selRed     = selEntry[RED_LSB +: 8];

    function automatic logic [7:0] pick_byte(input logic [23:0] ent, input vpa_seq_t sel);
        logic [7:0] b;
        b = ent[BLUE_LSB +: 8];
        if (sel == SEQ_RED) begin
            b = ent[RED_LSB +: 8];
        end else if (sel == SEQ_GREEN) begin
            b = ent[GREEN_LSB +: 8];
        end
        return b;
    endfunction

    // Byte sequencer shared by reads and writes; no display-mode gating
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            byteSel <= SEQ_RED;
        end else if (rdIdxWr || wrIdxWr) begin
            byteSel <= SEQ_RED;
        end else if (dataWr || dataRd) begin
            unique case (byteSel)
                SEQ_RED:   byteSel <= SEQ_GREEN;
                SEQ_GREEN: byteSel <= SEQ_BLUE;
                SEQ_BLUE:  byteSel <= SEQ_RED;
                default:   byteSel <= SEQ_RED;
            endcase
        end
    end

    // Partial bytes are only held; a later index write simply discards them
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            redHeld   <= 8'h00;
            greenHeld <= 8'h00;
        end else if (dataWr && byteSel == SEQ_RED) begin
            redHeld <= busWrData;
        end else if (dataWr && byteSel == SEQ_GREEN) begin
            greenHeld <= busWrData;
        end
    end

    // Read index; 8-bit wrap from 255 to zero is natural overflow
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            readIndex <= INDEX_RST;
        end else if (rdIdxWr) begin
            readIndex <= busWrData;
        end else if (dataRd && byteSel == SEQ_BLUE) begin
            readIndex <= readIndex + 8'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            writeIndex <= INDEX_RST;
        end else if (wrIdxWr) begin
            writeIndex <= busWrData;
        end else if (commit) begin
            writeIndex <= writeIndex + 8'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            indexState <= STATE_WR;
        end else if (rdIdxWr) begin
            indexState <= STATE_RD;
        end else if (wrIdxWr) begin
            indexState <= STATE_WR;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pixelMask <= MASK_RST;
        end else if (busWrite && busAddr == OFF_MASK) begin
            pixelMask <= busWrData;
        end
    end

    // Read mux; unmapped and write-only addresses return zero
    always_comb begin
        next_rdData = UNMAPPED_RD;
        unique case (busAddr)
            OFF_MASK:     next_rdData = pixelMask;
            OFF_RD_STATE: next_rdData = {6'h00, indexState};
            OFF_DATA:     next_rdData = pick_byte(selEntry, byteSel);
            default:      next_rdData = UNMAPPED_RD;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            busRdData  <= 8'h00;
            busRdValid <= 1'b0;
        end else begin
            busRdValid <= busRead;
            if (busRead) begin
                busRdData <= next_rdData;
            end
        end
    end

    // One palette per pipe; host accesses steered by palSel
    for (genvar g = 0; g < NUM_PIPES; g++) begin : g_pipe
        assign lookIdx[g] = idxMode[g] ? (pixIndex[g] & pixelMask) : pixIndex[g];
        assign collide[g] = commit && (palSel == 1'(g)) && pixValid[g]
                            && (writeIndex == lookIdx[g]);

        vpa_palette_ram #(
            .ENTRIES (256)
        ) u_ram (
            .sysClk   (sys_clk),
            .wrEn     (commit && (palSel == 1'(g))),
            .wrAddr   (writeIndex),
            .wrData   (commitData),
            .hostAddr (readIndex),
            .hostData (hostData[g]),
            .lookAddr (lookIdx[g]),
            .lookData (lookData[g])
        );

        // Anti-sparkle: a colliding lookup repeats the last colour sent
        always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
                pixColour[g]      <= 24'h000000;
                pixColourValid[g] <= 1'b0;
            end else begin
                pixColourValid[g] <= pixValid[g];
                if (pixValid[g] && !collide[g]) begin
                    pixColour[g] <= lookData[g];
                end
            end
        end
    end

    seq_reset_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (rdIdxWr || wrIdxWr) |=> (byteSel == SEQ_RED))
        else $error("Sequencer not at red after index write");

    state_read_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        rdIdxWr |=> (indexState == STATE_RD))
        else $error("State not 11 after read index write");

    state_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (wrIdxWr && !rdIdxWr) |=> (indexState == STATE_WR))
        else $error("State not 00 after write index write");

    read_incr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (dataRd && !busWrite && byteSel == SEQ_BLUE)
        |=> (readIndex == $past(readIndex) + 8'h01))
        else $error("Read index did not advance after blue read");

    write_incr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (commit) |=> (writeIndex == $past(writeIndex) + 8'h01))
        else $error("Write index did not advance after blue write");

    three_bytes_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (wrIdxWr ##1 (dataWr && !rdIdxWr) ##1 (dataWr && !rdIdxWr)) |-> !commit)
        else $error("Entry committed before third byte");

    abandon_wr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        rdIdxWr |=> !commit)
        else $error("Partial write survived read index load");

    red_first_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (rdIdxWr ##1 (dataRd && !busWrite))
        |=> (busRdData == $past(selRed)))
        else $error("First read after index load not red");

    mask_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (pixValid[0] && idxMode[0]) |-> ((lookIdx[0] & ~pixelMask) == 8'h00))
        else $error("Masked index bit leaked");

    sparkle_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        collide[0] |=> $stable(pixColour[0]) && pixColourValid[0])
        else $error("Colliding lookup changed pixel output");

    lookup_pass_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (pixValid[0] && !collide[0]) |=> (pixColour[0] == $past(lookData[0])))
        else $error("Lookup colour not delivered");

    read_answer_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        busRead |=> busRdValid)
        else $error("Read not answered one cycle later");

    rdvalid_low_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !busRead |=> !busRdValid)
        else $error("Read valid without a read");

    green_next_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (dataRd && !busWrite && byteSel == SEQ_RED) |=> (byteSel == SEQ_GREEN))
        else $error("Sequencer did not move to green");

    read_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (dataRd && !busWrite && byteSel != SEQ_BLUE) |=> $stable(readIndex))
        else $error("Read index moved before blue read");

    red_held_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (dataWr && byteSel == SEQ_RED) |=> (redHeld == $past(busWrData)))
        else $error("Red byte not held");

    commit_land_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (commit && !palSel && (writeIndex == readIndex)) |=> (hostData[0] == $past(commitData)))
        else $error("Committed entry not stored");

    partial_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (dataWr && byteSel != SEQ_BLUE) |=> $stable(writeIndex))
        else $error("Write index moved before blue write");

    write_load_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wrIdxWr |=> (writeIndex == $past(busWrData)))
        else $error("Write index not loaded");

    mask_load_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (busWrite && busAddr == OFF_MASK) |=> (pixelMask == $past(busWrData)))
        else $error("Pixel mask not loaded");

    raw_index_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (pixValid[0] && !idxMode[0]) |-> (lookIdx[0] == pixIndex[0]))
        else $error("Unmasked lookup index altered");

    state_code_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (indexState == STATE_WR) || (indexState == STATE_RD))
        else $error("State holds a reserved code");

    seq_any_mode_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ((dataRd || dataWr) && !rdIdxWr && !wrIdxWr) |=> (byteSel != $past(byteSel)))
        else $error("Data access did not advance sequencer");

    read_wrap_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (dataRd && !busWrite && byteSel == SEQ_BLUE && readIndex == 8'hff) |=> (readIndex == 8'h00))
        else $error("Read index did not wrap to zero");

    write_wrap_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (commit && writeIndex == 8'hff) |=> (writeIndex == 8'h00) && (byteSel == SEQ_RED))
        else $error("Write index did not wrap to zero");

    state_load_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (busRead && busAddr == OFF_RD_STATE) |=> (busRdData == {6'h00, $past(indexState)}))
        else $error("Shared address read did not give state");

    read_load_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        rdIdxWr |=> (readIndex == $past(busWrData)))
        else $error("Shared address write did not load read index");
endmodule

// *** core/vpa_palette_ram.sv ***
// One palette: 256 entries of red, green and blue bytes
`timescale 1ns/1ps
module vpa_palette_ram #(
    parameter int ENTRIES = 256
) (
    input  wire logic        sysClk,
    input  wire logic        wrEn,
    input  wire logic [7:0]  wrAddr,
    input  wire logic [23:0] wrData,
    input  wire logic [7:0]  hostAddr,
    output logic      [23:0] hostData,
    input  wire logic [7:0]  lookAddr,
    output logic      [23:0] lookData
);
    logic [23:0] entry [ENTRIES];

    // Whole entry written at once, never a partial colour
    always_ff @(posedge sysClk) begin
        if (wrEn) begin
            entry[wrAddr] <= wrData;
        end
    end

    // Reads are combinational so the host sees an increment at once
    assign hostData = entry[hostAddr];
    assign lookData = entry[lookAddr];
endmodule

// *** core/vpa_pkg.sv ***
// Package with offsets, codes and reset values for the palette access port
package vpa_pkg;
    localparam int          ADDR_W       = 16;
    localparam logic [15:0] OFF_MASK     = 16'h03c6;
    localparam logic [15:0] OFF_RD_STATE = 16'h03c7;
    localparam logic [15:0] OFF_WR_INDEX = 16'h03c8;
    localparam logic [15:0] OFF_DATA     = 16'h03c9;
    localparam logic [1:0]  STATE_WR     = 2'h0;
    localparam logic [1:0]  STATE_RD     = 2'h3;
    localparam logic [7:0]  INDEX_RST    = 8'h00;
    localparam logic [7:0]  MASK_RST     = 8'hff;
    localparam logic [7:0]  UNMAPPED_RD  = 8'h00;
    localparam int          RED_LSB      = 16;
    localparam int          GREEN_LSB    = 8;
    localparam int          BLUE_LSB     = 0;

    typedef enum logic [1:0] {
        SEQ_RED,
        SEQ_GREEN,
        SEQ_BLUE
    } vpa_seq_t;
endpackage

// *** test/test_vpa_palette_port.sv ***
// Self-checking bench for the palette access port
`timescale 1ns/1ps
`define CHK(g, e) chk(24'(g), 24'(e))
module test_vpa_palette_port;
    import vpa_pkg::*;
    logic             sysClk;
    logic             sysRst;
    logic [15:0]      busAddr;
    logic             busWrite;
    logic             busRead;
    logic [7:0]       busWrData;
    logic [7:0]       busRdData;
    logic             busRdValid;
    logic             palSel;
    logic [1:0]       pixValid;
    logic [1:0]       idxMode;
    logic [1:0][7:0]  pixIndex;
    logic [1:0][23:0] pixColour;
    logic [1:0]       pixColourValid;
    logic [23:0]      pal[2][256];
    logic [23:0]      lastCol[2];
    logic [23:0]      pixQ[$];
    int               errors;
    int               checks;
    vpa_host_model u_vpa_host_model (.sysClk(sysClk), .busAddr(busAddr), .busWrite(busWrite),
        .busRead(busRead), .busWrData(busWrData), .palSel(palSel));
    vpa_palette_port #(.NUM_PIPES(2)) u_vpa_palette_port (.sys_clk(sysClk), .sys_rst(sysRst),
        .busAddr(busAddr), .busWrite(busWrite), .busRead(busRead), .busWrData(busWrData),
        .busRdData(busRdData), .busRdValid(busRdValid), .palSel(palSel),
        .pixValid(pixValid), .idxMode(idxMode), .pixIndex(pixIndex),
        .pixColour(pixColour), .pixColourValid(pixColourValid));
    initial begin
        sysClk = 1'b0;
        forever #5 sysClk = ~sysClk;
    end
    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        checks++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic summarize();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic wrEntries(input logic s, input logic [7:0] idx, input int n);
        logic [23:0] c;
        u_vpa_host_model.wr(OFF_WR_INDEX, idx, s);
        for (int k = 0; k < 3 * n; k++) begin
            if (k % 3 == 0) c = 24'($urandom);
            u_vpa_host_model.wr(OFF_DATA, c[23 - 8 * (k % 3) -: 8], s);
            if (k % 3 == 2) pal[s][8'(idx + k / 3)] = c;
        end
        u_vpa_host_model.rel();
    endtask
    // Read index is loaded before the data port is read
    task automatic rdEntries(input logic s, input logic [7:0] idx, input int n);
        logic [23:0] c;
        u_vpa_host_model.wr(OFF_RD_STATE, idx, s);
        for (int k = 0; k < 3 * n; k++) begin
            c = pal[s][8'(idx + k / 3)];
            u_vpa_host_model.rd(OFF_DATA, c[23 - 8 * (k % 3) -: 8], s);
        end
        u_vpa_host_model.rel();
    endtask
    task automatic look(input int p, input logic [7:0] i, input logic m, input logic [23:0] e);
        @(negedge sysClk);
        pixValid[p] = 1'b1;
        pixIndex[p] = i;
        idxMode[p] = m;
        pixQ.push_back(e);
        lastCol[p] = e;
        @(negedge sysClk);
        pixValid[p] = 1'b0;
        pixIndex[p] = ~i;
    endtask
    // Registered outputs are settled by the falling edge
    always @(negedge sysClk) begin
        if (busRdValid === 1'b1) begin
            if (u_vpa_host_model.expQ.size() > 0) begin
                `CHK(busRdData, u_vpa_host_model.expQ.pop_front());
            end else `CHK(0, 1);
        end
        for (int p = 0; p < 2; p++) begin
            if (pixColourValid[p] === 1'b1) begin
                if (pixQ.size() > 0) `CHK(pixColour[p], pixQ.pop_front());
                else `CHK(0, 1);
            end
        end
    end
    initial begin
        logic [23:0] c;
        sysRst = 1'b1;
        pixValid = '0;
        idxMode = '0;
        pixIndex = '0;
        errors = 0;
        checks = 0;
        void'($urandom(42901));
        repeat (6) @(posedge sysClk);
        @(negedge sysClk);
        sysRst = 1'b0;
        u_vpa_host_model.rd(OFF_RD_STATE, {6'h00, STATE_WR}, 1'b0);
        u_vpa_host_model.rd(OFF_MASK, MASK_RST, 1'b0);
        u_vpa_host_model.rd(OFF_WR_INDEX, UNMAPPED_RD, 1'b0);
        u_vpa_host_model.rd(16'h03c5, UNMAPPED_RD, 1'b0);
        u_vpa_host_model.rel();
        for (int s = 0; s < 2; s++) wrEntries(1'(s), 8'hfe, 3);
        u_vpa_host_model.wr(OFF_WR_INDEX, 8'h00, 1'b0);
        u_vpa_host_model.wr(OFF_DATA, 8'h5a, 1'b0);
        u_vpa_host_model.wr(OFF_DATA, 8'ha5, 1'b0); // broken on purpose
        for (int s = 0; s < 2; s++) rdEntries(1'(s), 8'hfe, 3);
        u_vpa_host_model.rd(OFF_RD_STATE, {6'h00, STATE_RD}, 1'b0);
        c = pal[1][8'hfe];
        u_vpa_host_model.wr(OFF_RD_STATE, 8'hfe, 1'b1);
        u_vpa_host_model.rd(OFF_DATA, c[23:16], 1'b1);
        u_vpa_host_model.wr(OFF_WR_INDEX, 8'h01, 1'b1);
        for (int k = 0; k < 3; k++) u_vpa_host_model.rd(OFF_DATA, c[23 - 8 * k -: 8], 1'b1);
        c = 24'($urandom);
        for (int k = 0; k < 3; k++) u_vpa_host_model.wr(OFF_DATA, c[23 - 8 * k -: 8], 1'b1);
        pal[1][1] = c;
        c = pal[1][8'hff];
        for (int k = 0; k < 3; k++) u_vpa_host_model.rd(OFF_DATA, c[23 - 8 * k -: 8], 1'b1);
        u_vpa_host_model.wr(OFF_MASK, 8'h00, 1'b0);
        u_vpa_host_model.rd(OFF_MASK, 8'h00, 1'b0);
        u_vpa_host_model.rel();
        look(0, 8'($urandom), 1'b1, pal[0][0]);
        look(1, 8'h01, 1'b0, pal[1][1]);
        u_vpa_host_model.wr(OFF_MASK, 8'hfe, 1'b0);
        u_vpa_host_model.rel();
        look(1, 8'hff, 1'b1, pal[1][8'hfe]);
        u_vpa_host_model.wr(OFF_WR_INDEX, 8'hff, 1'b0);
        c = 24'($urandom);
        u_vpa_host_model.wr(OFF_DATA, c[23:16], 1'b0);
        u_vpa_host_model.wr(OFF_DATA, c[15:8], 1'b0);
        fork
            begin
                u_vpa_host_model.wr(OFF_DATA, c[7:0], 1'b0);
                u_vpa_host_model.rel();
            end
            look(0, 8'hff, 1'b0, lastCol[0]); // broken on purpose
        join
        pal[0][8'hff] = c;
        look(0, 8'hff, 1'b0, c);
        for (int i = 0; i < 20 && u_vpa_host_model.expQ.size() + pixQ.size() > 0; i++)
            @(posedge sysClk);
        if (u_vpa_host_model.expQ.size() + pixQ.size() > 0) errors++;
        summarize();
    end
endmodule

// *** test/vpa_host_model.sv ***
// Host processor model driving byte accesses into the palette port
`timescale 1ns/1ps
module vpa_host_model (
    input  wire logic        sysClk,
    output logic      [15:0] busAddr,
    output logic             busWrite,
    output logic             busRead,
    output logic      [7:0]  busWrData,
    output logic             palSel
);
    logic [7:0] expQ[$];
    initial begin
        busAddr = 16'h0000;
        busWrite = 1'b0;
        busRead = 1'b0;
        busWrData = 8'h00;
        palSel = 1'b0;
    end
    // Strobe stays up across back-to-back calls; one access per edge
    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d, input logic s);
        @(negedge sysClk);
        busWrite = w;
        busRead = !w;
        busAddr = a;
        busWrData = d;
        palSel = s;
        @(posedge sysClk);
    endtask
    // Index writes only follow whole entries unless the bench orders otherwise
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic s);
        acc(1'b1, a, d, s);
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic s);
        expQ.push_back(e);
        acc(1'b0, a, 8'h00, s);
    endtask
    // Released lines show the inverse so a stale value cannot pass
    task automatic rel();
        @(negedge sysClk);
        busWrite = 1'b0;
        busRead = 1'b0;
        busAddr = ~busAddr;
        busWrData = ~busWrData;
    endtask
endmodule
